// >>> design/link_target.sv
// two-wire management bus target running on the serial clock
module link_target #(
   parameter logic [7:0] IDENT = 8'h5a  // arbitrary identifier value
) (
   input wire logic scl,
   input wire logic link_rst,
   input wire logic bus_en,
   input wire logic [mgmt_pkg::IMG_W-1:0] rd_img,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic wr_tgl,
   output logic rd_tgl,
   output logic [7:0] wr_addr,
   output logic [7:0] wr_data,
   output logic [15:0] rd_clr
);
   import mgmt_pkg::*;
   logic [1:0] lrst_q;
   logic lrst;
   logic [IMG_W:0] img_meta_q;
   logic [IMG_W:0] img_q;
   logic sda_rise_q, start_tgl_q, stop_tgl_q, start_seen_q, stop_seen_q;
   logic start_w, stop_w, load_w, rw_q, wr_pend_q, rd_any_q;
   logic sda_out_q, sda_oe_q, wr_tgl_q, rd_tgl_q;
   link_state_e state_q;
   logic [2:0] cnt_q;
   logic [7:0] shift_q, ptr_q, tx_q, tx_w, byte_in, wr_addr_q, wr_data_q;
   logic [15:0] acc_q, rd_clr_q;

   assign lrst = lrst_q[1];
   assign sda_out = sda_out_q;
   assign sda_oe = sda_oe_q;
   assign wr_tgl = wr_tgl_q;
   assign rd_tgl = rd_tgl_q;
   assign wr_addr = wr_addr_q;
   assign wr_data = wr_data_q;
   assign rd_clr = rd_clr_q;

   // reset asserts at once, releases on serial clock edges
   always_ff @(posedge scl or posedge link_rst) begin
      if (link_rst) lrst_q <= '1;
      else lrst_q <= {lrst_q[0], 1'b0};
   end

   // image and bus enable are resampled through two flip-flops on each rising serial clock
   always_ff @(posedge scl) begin
      img_meta_q <= {bus_en, rd_img};
      img_q <= img_meta_q;
      sda_rise_q <= sda_in;
   end

   // start and stop seen as data edges while the clock is high
   always_ff @(negedge sda_in or posedge lrst) begin
      if (lrst) start_tgl_q <= 1'b0;
      else if (scl) start_tgl_q <= ~start_tgl_q;
   end
   always_ff @(posedge sda_in or posedge lrst) begin
      if (lrst) stop_tgl_q <= 1'b0;
      else if (scl) stop_tgl_q <= ~stop_tgl_q;
   end
   always_ff @(negedge scl or posedge lrst) begin
      if (lrst) begin
         start_seen_q <= 1'b0;
         stop_seen_q <= 1'b0;
         sda_out_q <= 1'b0;
      end else begin
         start_seen_q <= start_tgl_q;
         stop_seen_q <= stop_tgl_q;
         sda_out_q <= 1'b0;
      end
   end
   assign start_w = start_tgl_q ^ start_seen_q;
   assign stop_w = stop_tgl_q ^ stop_seen_q;
   assign byte_in = {shift_q[6:0], sda_rise_q};
   assign load_w = (state_q == L_AACK && rw_q) || (state_q == L_RACK && !sda_rise_q);

   always_comb begin
      case (ptr_q)
         ADR_ID: tx_w = IDENT;
         ADR_STATUS: tx_w = img_q[IMG_STATUS*8 +: 8];
         ADR_FLAG_LANE: tx_w = img_q[IMG_FLAG_LANE*8 +: 8];
         ADR_FLAG_MOD: tx_w = img_q[IMG_FLAG_MOD*8 +: 8];
         ADR_MASK_LANE: tx_w = img_q[IMG_MASK_LANE*8 +: 8];
         ADR_MASK_MOD: tx_w = img_q[IMG_MASK_MOD*8 +: 8];
         ADR_CTRL: tx_w = img_q[IMG_CTRL*8 +: 8];
         default: tx_w = BYTE_ZERO;
      endcase
   end

   always_ff @(negedge scl or posedge lrst) begin
      if (lrst) begin
         state_q <= L_IDLE;
         cnt_q <= '0;
         shift_q <= '0;
         ptr_q <= '0;
         tx_q <= '0;
         rw_q <= 1'b0;
         wr_pend_q <= 1'b0;
         rd_any_q <= 1'b0;
         acc_q <= '0;
         sda_oe_q <= 1'b0;
         wr_tgl_q <= 1'b0;
         rd_tgl_q <= 1'b0;
         wr_addr_q <= '0;
         wr_data_q <= '0;
         rd_clr_q <= '0;
      end else begin
         if (stop_w) begin
            // hand-over happens on the first falling clock after a stop
            if (wr_pend_q) wr_tgl_q <= ~wr_tgl_q;
            if (rd_any_q) begin
               rd_tgl_q <= ~rd_tgl_q;
               rd_clr_q <= acc_q;
            end
            wr_pend_q <= 1'b0;
            rd_any_q <= 1'b0;
            acc_q <= '0;
         end
         if (start_w || stop_w) begin
            state_q <= start_w ? L_ADDR : L_IDLE;
            cnt_q <= '0;
            sda_oe_q <= 1'b0;
         end else begin
            cnt_q <= cnt_q + 3'h1;
            unique case (state_q)
               L_IDLE: begin
                  cnt_q <= '0;
               end
               L_ADDR: begin
                  shift_q <= byte_in;
                  if (cnt_q == 3'h7) begin
                     if (byte_in[7:1] == DEV_ADDR && img_q[IMG_W]) begin
                        rw_q <= byte_in[0];
                        sda_oe_q <= 1'b1;
                        state_q <= L_AACK;
                     end else begin
                        state_q <= L_IDLE;
                     end
                  end
               end
               L_AACK: begin
                  cnt_q <= '0;
                  sda_oe_q <= 1'b0;
                  state_q <= L_REG;
               end
               L_REG: begin
                  shift_q <= byte_in;
                  if (cnt_q == 3'h7) begin
                     ptr_q <= byte_in;
                     sda_oe_q <= 1'b1;
                     state_q <= L_REG_ACK;
                  end
               end
               L_REG_ACK, L_WACK: begin
                  cnt_q <= '0;
                  sda_oe_q <= 1'b0;
                  state_q <= L_WDATA;
               end
               L_WDATA: begin
                  shift_q <= byte_in;
                  if (cnt_q == 3'h7) begin
                     wr_addr_q <= ptr_q;
                     wr_data_q <= byte_in;
                     wr_pend_q <= 1'b1;
                     ptr_q <= ptr_q + 8'h01;
                     sda_oe_q <= 1'b1;
                     state_q <= L_WACK;
                  end
               end
               L_RDATA: begin
                  if (cnt_q == 3'h7) begin
                     sda_oe_q <= 1'b0;
                     state_q <= L_RACK;
                  end else begin
                     sda_oe_q <= ~tx_q[7];
                     tx_q <= {tx_q[6:0], 1'b0};
                  end
               end
               L_RACK: begin
                  cnt_q <= '0;
                  sda_oe_q <= 1'b0;
                  state_q <= L_IDLE;
               end
            endcase
            if (load_w) begin
               tx_q <= {tx_w[6:0], 1'b0};
               sda_oe_q <= ~tx_w[7];
               ptr_q <= ptr_q + 8'h01;
               cnt_q <= '0;
               state_q <= L_RDATA;
               // flag bytes sent to the host are remembered for clearing
               if (ptr_q == ADR_FLAG_LANE) begin
                  acc_q[7:0] <= acc_q[7:0] | tx_w;
                  rd_any_q <= 1'b1;
               end
               if (ptr_q == ADR_FLAG_MOD) begin
                  acc_q[15:8] <= acc_q[15:8] | tx_w;
                  rd_any_q <= 1'b1;
               end
            end
         end
      end
   end

   AST_ADDR_ACK: assert property (@(negedge scl) disable iff (lrst)
      (state_q == L_AACK) |-> (shift_q[7:1] == DEV_ADDR && sda_oe_q))
      else $error("acknowledged a foreign bus address");
   AST_STOP_HANDOVER: assert property (@(negedge scl) disable iff (lrst)
      (stop_w && rd_any_q) |=> (rd_tgl_q != $past(rd_tgl_q)))
      else $error("read not handed over at the fall after stop");
   COV_WRITE_ACK: cover property (@(negedge scl) disable iff (lrst) state_q == L_WACK);
endmodule

// >>> design/mgmt_control.sv
// management sideband of a pluggable module: reset, init, flags, interrupt, power
// Summary of operation
// - after power-up or reset release, become fully functional within 2000 ms.
// - reset input low counts only when longer than 2 us; host holds it so.
// - from reset input rising edge, reach fully functional within 2000 ms.
// - answer management bus transactions no later than 2000 ms after power-up.
// - within 2000 ms, clear data-not-ready status bit 0 byte 2 and assert interrupt.
// - low power request high drops module to low power within 100 us.
// - an interrupting condition pulls interrupt output low within 200 ms.
// - flags clear on read; interrupt releases within 500 us after clearing read.
// - receive loss of signal sets its flag and asserts interrupt within 100 ms.
// - other flag conditions set their flag and assert interrupt within 200 ms.
// - a set mask bit stops its flag raising interrupt within 100 ms.
// - a cleared mask bit lets its flag raise interrupt again within 100 ms.
// - after select asserts, answer bus within 100 us; host waits that long.
// - after select deasserts, stop answering the bus within 100 us.
// - software power-down bit set enters low power within 100 ms.
// - power-down bit cleared returns to full function within 300 ms.
// - full function is signalled by interrupt from data-not-ready being cleared.
// - response times count from the falling serial clock after stop.
// - the bus target answers at address A0h; host uses that address.
module mgmt_control #(
   parameter int INIT_CYCLES = mgmt_pkg::INIT_CYC
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic module_reset_n,
   input wire logic module_select_n,
   input wire logic low_power_request,
   input wire logic [mgmt_pkg::LANES-1:0] rx_los,
   input wire logic [mgmt_pkg::LANES-1:0] tx_fault,
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic intl_n,
   output logic low_power_active,
   output logic module_present_n
);
   import mgmt_pkg::*;

   localparam int IW = $clog2(INIT_CYCLES + 1);
   localparam int RW = $clog2(RESET_MIN_CYC + 1);
   localparam logic [IW-1:0] INIT_LAST = IW'(INIT_CYCLES - 1);
   localparam logic [RW-1:0] RESET_LAST = RW'(RESET_MIN_CYC);

   logic [2:0] pin_meta_q;
   logic [2:0] pin_q;
   logic mrst_n_s, sel_n_s, lp_s;
   logic [RW-1:0] mrst_cnt_q;
   logic in_reset_q;
   init_state_e state_q;
   logic [IW-1:0] init_cnt_q;
   logic init_done_w;
   logic status_nr_q;
   logic link_rst_q;
   logic [1:0] tgl_meta_q;
   logic [1:0] tgl_sync_q;
   logic [1:0] tgl_seen_q;
   logic wr_evt, rd_evt;
   logic wr_tgl, rd_tgl;
   logic [7:0] wr_addr, wr_data;
   logic [15:0] rd_clr;
   logic [7:0] ctrl_q, mask_lane_q, mask_mod_q;
   logic [LANES-1:0] rx_los_q, tx_fault_q;
   logic [7:0] flag_lane_q, flag_mod_q;
   logic [7:0] lane_set, lane_clr, mod_set, mod_clr;
   logic irq_w;
   logic intl_n_q, lp_q, bus_en_q, present_n_q;
   logic [7:0] status_byte;
   logic [IMG_W-1:0] rd_img;

   // pins from the host pass two flip-flops before use
   always_ff @(posedge clock) begin
      if (rst) begin
         pin_meta_q <= PIN_IDLE;
         pin_q <= PIN_IDLE;
      end else begin
         pin_meta_q <= {low_power_request, module_select_n, module_reset_n};
         pin_q <= pin_meta_q;
      end
   end
   assign mrst_n_s = pin_q[0];
   assign sel_n_s = pin_q[1];
   assign lp_s = pin_q[2];

   // a low reset pin counts only once it outlasts the least pulse
   always_ff @(posedge clock) begin
      if (rst) begin
         mrst_cnt_q <= '0;
         in_reset_q <= 1'b0;
      end else if (mrst_n_s) begin
         mrst_cnt_q <= '0;
         in_reset_q <= 1'b0;
      end else if (mrst_cnt_q == RESET_LAST) begin
         in_reset_q <= 1'b1;
      end else begin
         mrst_cnt_q <= mrst_cnt_q + RW'(1);
      end
   end

   // initialisation restarts on power-up and on release of a qualified reset
   always_ff @(posedge clock) begin
      if (rst || in_reset_q) begin
         state_q <= INIT_WAIT;
         init_cnt_q <= '0;
      end else begin
         unique case (state_q)
            INIT_WAIT: begin
               if (init_done_w) state_q <= READY;
               else init_cnt_q <= init_cnt_q + IW'(1);
            end
            READY: begin
               init_cnt_q <= init_cnt_q;
            end
         endcase
      end
   end
   assign init_done_w = (state_q == INIT_WAIT) && (init_cnt_q == INIT_LAST);

   always_ff @(posedge clock) begin
      if (rst || in_reset_q) status_nr_q <= 1'b1;
      else if (init_done_w) status_nr_q <= 1'b0;
   end

   // serial side is held in reset until the host-facing logic is out of it
   always_ff @(posedge clock) begin
      if (rst) link_rst_q <= 1'b1;
      else link_rst_q <= in_reset_q;
   end

   // write and read completions arrive as toggles; data stay held meanwhile
   always_ff @(posedge clock) begin
      if (rst || link_rst_q) begin
         tgl_meta_q <= '0;
         tgl_sync_q <= '0;
         tgl_seen_q <= '0;
      end else begin
         tgl_meta_q <= {rd_tgl, wr_tgl};
         tgl_sync_q <= tgl_meta_q;
         tgl_seen_q <= tgl_sync_q;
      end
   end
   assign wr_evt = tgl_sync_q[0] ^ tgl_seen_q[0];
   assign rd_evt = tgl_sync_q[1] ^ tgl_seen_q[1];

   // host-written control and mask bytes
   always_ff @(posedge clock) begin
      if (rst || in_reset_q) begin
         ctrl_q <= BYTE_ZERO;
         mask_lane_q <= BYTE_ZERO;
         mask_mod_q <= BYTE_ZERO;
      end else if (wr_evt) begin
         if (wr_addr == ADR_CTRL) ctrl_q <= wr_data;
         if (wr_addr == ADR_MASK_LANE) mask_lane_q <= wr_data;
         if (wr_addr == ADR_MASK_MOD) mask_mod_q <= wr_data;
      end
   end

   // flags latch on a rising condition; a new event beats a clearing read
   always_ff @(posedge clock) begin
      if (rst) begin
         rx_los_q <= '0;
         tx_fault_q <= '0;
      end else begin
         rx_los_q <= rx_los;
         tx_fault_q <= tx_fault;
      end
   end
   assign lane_set = {tx_fault & ~tx_fault_q, rx_los & ~rx_los_q};
   assign lane_clr = rd_evt ? rd_clr[7:0] : BYTE_ZERO;
   assign mod_set = init_done_w ? (8'h01 << READY_BIT) : BYTE_ZERO;
   assign mod_clr = rd_evt ? rd_clr[15:8] : BYTE_ZERO;

   always_ff @(posedge clock) begin
      if (rst || in_reset_q) begin
         flag_lane_q <= BYTE_ZERO;
         flag_mod_q <= BYTE_ZERO;
      end else begin
         flag_lane_q <= (flag_lane_q & ~lane_clr) | lane_set;
         flag_mod_q <= (flag_mod_q & ~mod_clr) | mod_set;
      end
   end

   // interrupt: any unmasked flag pulls the line low
   assign irq_w = |(flag_lane_q & ~mask_lane_q) || |(flag_mod_q & ~mask_mod_q);
   always_ff @(posedge clock) begin
      if (rst || in_reset_q) intl_n_q <= 1'b1;
      else intl_n_q <= ~irq_w;
   end

   // low power from the pin or from the software power-down bit
   always_ff @(posedge clock) begin
      if (rst) lp_q <= 1'b0;
      else lp_q <= lp_s || ctrl_q[PDOWN_BIT];
   end

   // bus answers only once ready and while selected
   always_ff @(posedge clock) begin
      if (rst || in_reset_q) bus_en_q <= 1'b0;
      else bus_en_q <= (state_q == READY) && !sel_n_s;
   end

   always_ff @(posedge clock) begin
      if (rst) present_n_q <= 1'b0;
      else present_n_q <= 1'b0;
   end

   assign status_byte = {7'h00, status_nr_q} << NR_BIT;
   assign rd_img = {ctrl_q, mask_mod_q, mask_lane_q, flag_mod_q, flag_lane_q, status_byte};

   link_target u_link (
      .scl(scl),
      .link_rst(link_rst_q),
      .bus_en(bus_en_q),
      .rd_img(rd_img),
      .sda_in(sda_in),
      .sda_out(sda_out),
      .sda_oe(sda_oe),
      .wr_tgl(wr_tgl),
      .rd_tgl(rd_tgl),
      .wr_addr(wr_addr),
      .wr_data(wr_data),
      .rd_clr(rd_clr)
   );

   assign intl_n = intl_n_q;
   assign low_power_active = lp_q;
   assign module_present_n = present_n_q;

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   AST_RESET_QUAL: assert property (
      $rose(in_reset_q) |-> ($past(mrst_cnt_q) == RESET_LAST && !$past(mrst_n_s)))
      else $error("reset taken before the least pulse elapsed");

   AST_RESET_SHORT: assert property (
      (!mrst_n_s && !in_reset_q && mrst_cnt_q < RESET_LAST) |=> !in_reset_q)
      else $error("short reset pulse was taken as a reset");

   AST_INIT_TIME: assert property (
      $rose(state_q == READY) |-> ($past(init_cnt_q) == INIT_LAST && !$past(in_reset_q)))
      else $error("ready reached at the wrong count");

   AST_INIT_NOT_READY: assert property (
      (state_q == INIT_WAIT) |-> (status_nr_q && !bus_en_q))
      else $error("bus or status ready during initialisation");

   AST_READY_IRQ: assert property (
      $rose(state_q == READY) |-> (!status_nr_q && flag_mod_q[READY_BIT])
         ##1 (!intl_n_q || mask_mod_q[READY_BIT] || in_reset_q))
      else $error("ready not signalled through status and interrupt");

   AST_SELECT_ON: assert property (
      (!sel_n_s && state_q == READY && !in_reset_q) |=> bus_en_q)
      else $error("selected and ready but bus not enabled");

   AST_SELECT_OFF: assert property (
      (sel_n_s || state_q != READY) |=> !bus_en_q)
      else $error("bus still enabled after deselect");

   AST_LP_ENTER: assert property (
      $rose(lp_s) |=> low_power_active)
      else $error("low power request not honoured");

   AST_PDOWN: assert property (
      (wr_evt && wr_addr == ADR_CTRL && wr_data[PDOWN_BIT] && mrst_n_s && !in_reset_q)
         |-> ##2 low_power_active)
      else $error("power-down write not honoured");

   AST_FLAG_LOS: assert property (
      (|(rx_los & ~rx_los_q) && !in_reset_q)
         |=> ((flag_lane_q[LANES-1:0] & $past(rx_los & ~rx_los_q))
            == $past(rx_los & ~rx_los_q)))
      else $error("loss of signal flag not set");

   AST_FLAG_FAULT: assert property (
      (|(tx_fault & ~tx_fault_q) && !in_reset_q)
         |=> ((flag_lane_q[2*LANES-1:LANES] & $past(tx_fault & ~tx_fault_q))
            == $past(tx_fault & ~tx_fault_q)))
      else $error("fault flag not set");

   AST_IRQ_ON: assert property (
      (|(flag_lane_q & ~mask_lane_q) && !in_reset_q) |=> !intl_n_q)
      else $error("unmasked flag did not pull interrupt low");

   AST_IRQ_OFF: assert property (
      ((flag_lane_q & ~mask_lane_q) == BYTE_ZERO && (flag_mod_q & ~mask_mod_q) == BYTE_ZERO)
         |=> intl_n_q)
      else $error("interrupt low with every flag masked or clear");

   AST_CLEAR_ON_READ: assert property (
      (rd_evt && !in_reset_q)
         |=> ((flag_lane_q & $past(rd_clr[7:0] & ~lane_set)) == BYTE_ZERO))
      else $error("read flag not cleared");

   COV_READY: cover property ($rose(state_q == READY));
   COV_CLEAR: cover property (rd_evt && |flag_lane_q);
   COV_MASK_WRITE: cover property (wr_evt && wr_addr == ADR_MASK_LANE);
endmodule

// >>> dv/host_model.sv
// host side of the two-wire management bus, data wire pulled up
module host_model (
   output logic scl,
   output logic sda_in,
   input wire logic sda_oe,
   input wire logic sda_out
);
   timeunit 1ns;
   timeprecision 1ps;
   import mgmt_pkg::*;
   logic sda_h;
   logic [7:0] rdata;
   event done;
   // a released wire reads high through the pull-up
   assign sda_in = sda_h & ~(sda_oe & ~sda_out);
   initial begin
      scl = 1'b1;
      sda_h = 1'b1;
   end
   task automatic bt(input logic b, output logic r);
      sda_h = b;
      #40 scl = 1'b1;
      #40 r = sda_in;
      #40 scl = 1'b0;
      #40;
   endtask
   task automatic xb(input logic [8:0] d, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         bt(d[i], r[i]);
      end
   endtask
   task automatic start();
      sda_h = 1'b1;
      #40 scl = 1'b1;
      #40 sda_h = 1'b0;
      #40 scl = 1'b0;
      #40;
   endtask
   // the extra falling edge after stop lets the target commit the frame
   task automatic stop();
      sda_h = 1'b0;
      #40 scl = 1'b1;
      #40 sda_h = 1'b1;
      #80 scl = 1'b0;
      #80 scl = 1'b1;
      #1000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [8:0] r;
      start();
      xb({DEV_ADDR, 1'b0, 1'b1}, r);
      xb({a, 1'b1}, r);
      xb({d, 1'b1}, r);
      stop();
   endtask
   task automatic rd(input logic [7:0] a);
      logic [8:0] r;
      start();
      xb({DEV_ADDR, 1'b0, 1'b1}, r);
      xb({a, 1'b1}, r);
      start();
      xb({DEV_ADDR, 1'b1, 1'b1}, r);
      xb(9'h1ff, r);
      stop();
      rdata = r[8:1];
      -> done;
   endtask
endmodule

// >>> dv/mgmt_control_test.sv
// self-checking bench of the module management sideband
module mgmt_control_test;
   timeunit 1ns;
   timeprecision 1ps;
   import mgmt_pkg::*;
   logic clock, rst, module_reset_n, module_select_n, low_power_request;
   logic [LANES-1:0] rx_los, tx_fault;
   logic scl, sda_in, sda_out, sda_oe, intl_n, low_power_active, module_present_n;
   int errors = 0;
   int n_checks = 0;
   integer seed = 32'hb65a;
   int lane;
   logic [7:0] exp_q[$];
   mgmt_control #(.INIT_CYCLES(50)) u_mgmt_control (.clock(clock), .rst(rst),
      .module_reset_n(module_reset_n), .module_select_n(module_select_n),
      .low_power_request(low_power_request), .rx_los(rx_los), .tx_fault(tx_fault),
      .scl(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .intl_n(intl_n),
      .low_power_active(low_power_active), .module_present_n(module_present_n));
   host_model u_host_model (.scl(scl), .sda_in(sda_in), .sda_oe(sda_oe), .sda_out(sda_out));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic pin(input logic v, input logic e);
      check({7'h00, v}, {7'h00, e});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #5;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      u_host_model.rd(a);
   endtask
   always @(u_host_model.done) begin
      check(u_host_model.rdata, exp_q.pop_front());
   end
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      #3_000_000;
      errors++;
      end_of_test();
   end
   initial begin
      rst = 1'b1;
      module_reset_n = 1'b1;
      module_select_n = 1'b0;
      low_power_request = 1'b0;
      rx_los = '0;
      tx_fault = '0;
      cyc(20);
      pin(intl_n, 1'b1);
      pin(low_power_active, 1'b0);
      pin(module_present_n, 1'b0);
      pin(sda_oe, 1'b0);
      pin(sda_out, 1'b0);
      rst = 1'b0;
      rd(ADR_ID, 8'hff);
      cyc(60);
      pin(intl_n, 1'b0);
      rd(ADR_STATUS, 8'h00);
      rd(ADR_ID, 8'h5a);
      rd(ADR_FLAG_MOD, 8'h01);
      rd(ADR_FLAG_MOD, 8'h00);
      cyc(10);
      pin(intl_n, 1'b1);
      lane = $random(seed) & 3;
      rx_los[lane] = 1'b1;
      cyc(3);
      pin(intl_n, 1'b0);
      rd(ADR_FLAG_LANE, 8'h01 << lane);
      cyc(10);
      pin(intl_n, 1'b1);
      rx_los = '0;
      u_host_model.wr(ADR_MASK_LANE, 8'hff);
      cyc(10);
      tx_fault[lane] = 1'b1;
      cyc(5);
      pin(intl_n, 1'b1);
      u_host_model.wr(ADR_MASK_LANE, 8'h00);
      cyc(10);
      pin(intl_n, 1'b0);
      rd(ADR_FLAG_LANE, 8'h10 << lane);
      cyc(1);
      tx_fault = '0;
      low_power_request = 1'b1;
      cyc(4);
      pin(low_power_active, 1'b1);
      low_power_request = 1'b0;
      cyc(4);
      pin(low_power_active, 1'b0);
      u_host_model.wr(ADR_CTRL, 8'h01);
      cyc(10);
      pin(low_power_active, 1'b1);
      rd(ADR_CTRL, 8'h01);
      u_host_model.wr(ADR_CTRL, 8'h00);
      cyc(10);
      pin(low_power_active, 1'b0);
      module_select_n = 1'b1;
      cyc(10);
      rd(ADR_ID, 8'hff);
      cyc(1);
      module_select_n = 1'b0;
      // host waits out the select settling time before talking
      cyc(1000);
      rd(ADR_ID, 8'h5a);
      u_host_model.wr(ADR_MASK_LANE, 8'h0f);
      cyc(1);
      module_reset_n = 1'b0;
      cyc(10);
      module_reset_n = 1'b1;
      cyc(10);
      rd(ADR_MASK_LANE, 8'h0f);
      cyc(1);
      // an unmasked fault pulls the line low so the long reset must release it
      tx_fault[lane] = 1'b1;
      cyc(3);
      pin(intl_n, 1'b0);
      module_reset_n = 1'b0;
      cyc(30);
      pin(intl_n, 1'b1);
      module_reset_n = 1'b1;
      cyc(60);
      pin(intl_n, 1'b0);
      rd(ADR_MASK_LANE, 8'h00);
      end_of_test();
   end
endmodule

// >>> shared/mgmt_pkg.sv
// constants, field positions and state types of the module management block
package mgmt_pkg;
   // time figures and clock rate
   localparam int CLK_HZ = 10_000_000;
   localparam int T_INIT_MS = 2000;
   localparam int T_RESET_MIN_US = 2;
   localparam int INIT_CYC = T_INIT_MS * (CLK_HZ / 1000);
   localparam int RESET_MIN_CYC = T_RESET_MIN_US * (CLK_HZ / 1_000_000);
   localparam int LANES = 4;
   // management bus target address (7-bit form of the A0h write address)
   localparam logic [6:0] DEV_ADDR = 7'h50;
   // byte addresses on the management bus
   localparam logic [7:0] ADR_ID = 8'h00;
   localparam logic [7:0] ADR_STATUS = 8'h02;
   localparam logic [7:0] ADR_FLAG_LANE = 8'h03;
   localparam logic [7:0] ADR_FLAG_MOD = 8'h04;
   localparam logic [7:0] ADR_CTRL = 8'h5d;
   localparam logic [7:0] ADR_MASK_LANE = 8'h64;
   localparam logic [7:0] ADR_MASK_MOD = 8'h65;
   // bit positions
   localparam int NR_BIT = 0;
   localparam int READY_BIT = 0;
   localparam int PDOWN_BIT = 0;
   // byte slots of the read-back image handed to the bus target
   localparam int IMG_STATUS = 0;
   localparam int IMG_FLAG_LANE = 1;
   localparam int IMG_FLAG_MOD = 2;
   localparam int IMG_MASK_LANE = 3;
   localparam int IMG_MASK_MOD = 4;
   localparam int IMG_CTRL = 5;
   localparam int IMG_W = 48;
   // idle levels of {low power request, select_n, reset_n}
   localparam logic [2:0] PIN_IDLE = 3'b011;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   typedef enum logic {INIT_WAIT, READY} init_state_e;
   typedef enum logic [3:0] {
      L_IDLE, L_ADDR, L_AACK, L_REG, L_REG_ACK, L_WDATA, L_WACK, L_RDATA, L_RACK
   } link_state_e;
endpackage
